// [hdl/sltcs_regs.vh]
`ifndef SLTCS_REGS_VH
`define SLTCS_REGS_VH

// Transmit control and status register fields.
`define SLTCS_TX_GO 0
`define SLTCS_TX_IDLE 1
`define SLTCS_TX_PAIR 2
`define SLTCS_TX_ERROR_IRQ_ENABLE 3
`define SLTCS_TX_MODEM_IE 4
`define SLTCS_DONE_IRQ_ENABLE 5
`define SLTCS_TX_DONE_S 6
`define SLTCS_TX_DONE_P 7
`define SLTCS_TX_RESET 16'h0000

// Receive status fields kept by this block.
`define SLTCS_RX_SYNC 12
`define SLTCS_RX_USER_LO 13
`define SLTCS_RX_USER_HI 14
`define SLTCS_RX_RESET 16'h0000

// Character path.
`define SLTCS_CHAR_BITS 8
`define SLTCS_DLE_CHAR 8'h10
`define SLTCS_MARK_CHAR 8'hff
`define SLTCS_FIFO_DEPTH 4

`endif

// [hdl/sltcs_sync.v]
`timescale 1ns/1ps
module sltcs_sync #(
  parameter WIDTH = 1
) (
  core_clk,
  rst,
  ce,
  async_in,
  sync_out
);
  input wire core_clk;
  input wire rst;
  input wire ce;
  input wire [WIDTH-1:0] async_in;
  output reg [WIDTH-1:0] sync_out;

  reg [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// [hdl/sltcs_fifo.v]
`timescale 1ns/1ps
module sltcs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  core_clk,
  rst,
  ce,
  flush,
  in_valid,
  in_data,
  in_ready,
  out_valid,
  out_data,
  out_ready
);
  input wire core_clk;
  input wire rst;
  input wire ce;
  input wire flush;
  input wire in_valid;
  input wire [WIDTH-1:0] in_data;
  output reg in_ready;
  output reg out_valid;
  output wire [WIDTH-1:0] out_data;
  input wire out_ready;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Full and empty are kept as flops so the ready and valid ports carry no logic.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (flush) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
        in_ready <= 1'b1;
        out_valid <= 1'b0;
      end else begin
        if (push) begin
          mem[wr_ptr_reg] <= in_data;
          wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
        end
        count_reg <= count_next;
        in_ready <= (count_next != DEPTH);
        out_valid <= (count_next != {(AW+1){1'b0}});
      end
    end
  end
endmodule

// [hdl/sltcs_top.v]
`timescale 1ns/1ps
`include "sltcs_regs.vh"

module sltcs_top #(
  parameter CHAR_BITS = `SLTCS_CHAR_BITS,
  parameter FIFO_DEPTH = `SLTCS_FIFO_DEPTH,
  parameter RECOG_OPTION = 1
) (
  core_clk,
  rst,
  ce,
  bus_init,
  master_clear,
  tx_wr_lo,
  tx_wr_hi,
  tx_wdata,
  tx_rdata,
  rx_wr_hi,
  rx_wdata,
  rx_rdata,
  seq_clear_go,
  seq_clear_sync,
  rx_run,
  rx_sync_set,
  vrc_error,
  bcc_error,
  nxm_flag,
  latency_flag,
  clock_loss_flag,
  prim_count_zero,
  sec_count_zero,
  char_count_overflow,
  transparent_mode,
  sync_char,
  mem_valid,
  mem_data,
  mem_ready,
  direct_memory_request,
  tx_clk,
  txd,
  tx_active,
  pair_select,
  error_flag,
  vector_b_request,
  user_option
);
  input wire core_clk;
  input wire rst;
  input wire ce;
  input wire bus_init;
  input wire master_clear;
  input wire tx_wr_lo;
  input wire tx_wr_hi;
  input wire [15:0] tx_wdata;
  output reg [15:0] tx_rdata;
  input wire rx_wr_hi;
  input wire [15:0] rx_wdata;
  output reg [15:0] rx_rdata;
  input wire seq_clear_go;
  input wire seq_clear_sync;
  input wire rx_run;
  input wire rx_sync_set;
  input wire vrc_error;
  input wire bcc_error;
  input wire nxm_flag;
  input wire latency_flag;
  input wire clock_loss_flag;
  input wire prim_count_zero;
  input wire sec_count_zero;
  input wire char_count_overflow;
  input wire transparent_mode;
  input wire [CHAR_BITS-1:0] sync_char;
  input wire mem_valid;
  input wire [CHAR_BITS-1:0] mem_data;
  output wire mem_ready;
  output reg direct_memory_request;
  input wire tx_clk;
  output reg txd;
  output reg tx_active;
  output reg pair_select;
  output reg error_flag;
  output reg vector_b_request;
  output reg [1:0] user_option;

  localparam CW = 4;
  localparam CB_LAST = CHAR_BITS - 1;

  localparam ST_IDLE = 2'd0;
  localparam ST_SHIFT = 2'd1;

  reg go_reg;
  reg idle_mode_reg;
  reg pair_reg;
  reg error_irq_enable_reg;
  reg modem_irq_enable_reg;
  reg done_irq_enable_reg;
  reg done_p_reg;
  reg done_s_reg;
  reg sync_flag_reg;
  reg [1:0] user_reg;
  reg rx_run_d_reg;
  reg [2:0] err_d_reg;
  reg tx_clk_d_reg;
  reg [1:0] state_reg;
  reg [CHAR_BITS-1:0] shift_reg;
  reg [CW-1:0] bit_cnt_reg;
  reg dle_sent_reg;
  reg go_next;
  reg [CHAR_BITS-1:0] load_char;
  reg load_mem;
  reg load_any;

  wire clear_all;
  wire tx_clk_s;
  wire tx_clk_rise;
  wire [2:0] err_now;
  wire err_rise;
  wire fifo_out_valid;
  wire [CHAR_BITS-1:0] fifo_out_data;
  wire fifo_pop;
  wire err_any;
  wire overflow_ev;
  wire idle_fill;

  assign clear_all = bus_init || master_clear;
  assign err_now = {nxm_flag, latency_flag, clock_loss_flag};
  assign err_rise = |(err_now & ~err_d_reg);
  assign err_any = vrc_error || bcc_error || nxm_flag || latency_flag || clock_loss_flag;
  assign overflow_ev = char_count_overflow && go_reg;
  assign idle_fill = idle_mode_reg && !go_reg;
  assign tx_clk_rise = tx_clk_s && !tx_clk_d_reg;
  assign fifo_pop = tx_clk_rise && (bit_cnt_reg == {CW{1'b0}}) && load_mem;

  sltcs_sync #(
    .WIDTH(1)
  ) u_clk_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async_in(tx_clk),
    .sync_out(tx_clk_s)
  );

  // Queued memory characters are dropped when the run bit goes low so a later
  // resume starts from the pair's address again instead of stale data.
  sltcs_fifo #(
    .WIDTH(CHAR_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .flush(!go_reg),
    .in_valid(mem_valid && go_reg),
    .in_data(mem_data),
    .in_ready(mem_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  always @* begin
    go_next = go_reg;
    if (tx_wr_lo) begin
      go_next = tx_wdata[`SLTCS_TX_GO];
    end
    if (clear_all || seq_clear_go) begin
      go_next = 1'b0;
    end
    if (err_rise) begin
      go_next = 1'b0;
    end
    if (prim_count_zero && sec_count_zero) begin
      go_next = 1'b0;
    end
  end

  // Next character chosen at each character boundary.
  always @* begin
    load_mem = 1'b0;
    load_any = 1'b1;
    load_char = `SLTCS_MARK_CHAR;
    if (go_reg && fifo_out_valid) begin
      load_mem = 1'b1;
      load_char = fifo_out_data;
    end else if (idle_fill) begin
      if (transparent_mode && (RECOG_OPTION != 0) && !dle_sent_reg) begin
        load_char = `SLTCS_DLE_CHAR;
      end else begin
        load_char = sync_char;
      end
    end else begin
      load_any = 1'b0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      go_reg <= 1'b0;
      idle_mode_reg <= 1'b0;
      pair_reg <= 1'b0;
      error_irq_enable_reg <= 1'b0;
      modem_irq_enable_reg <= 1'b0;
      done_irq_enable_reg <= 1'b0;
      done_p_reg <= 1'b0;
      done_s_reg <= 1'b0;
      err_d_reg <= 3'h0;
    end else if (ce) begin
      go_reg <= go_next;
      err_d_reg <= err_now;
      if (clear_all) begin
        idle_mode_reg <= 1'b0;
        pair_reg <= 1'b0;
        error_irq_enable_reg <= 1'b0;
        modem_irq_enable_reg <= 1'b0;
        done_irq_enable_reg <= 1'b0;
        done_p_reg <= 1'b0;
        done_s_reg <= 1'b0;
      end else begin
        // Pair-select takes no write data; it only follows overflows and bus init or master clear.
        if (tx_wr_lo) begin
          idle_mode_reg <= tx_wdata[`SLTCS_TX_IDLE];
          error_irq_enable_reg <= tx_wdata[`SLTCS_TX_ERROR_IRQ_ENABLE];
          modem_irq_enable_reg <= tx_wdata[`SLTCS_TX_MODEM_IE];
          done_irq_enable_reg <= tx_wdata[`SLTCS_DONE_IRQ_ENABLE];
          done_p_reg <= tx_wdata[`SLTCS_TX_DONE_P];
          done_s_reg <= tx_wdata[`SLTCS_TX_DONE_S];
        end
        if (overflow_ev) begin
          pair_reg <= !pair_reg;
          // A hardware set beats a same-cycle software clear.
          if (pair_reg) begin
            done_s_reg <= 1'b1;
          end else begin
            done_p_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Receive status bits.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_flag_reg <= 1'b0;
      user_reg <= 2'h0;
      rx_run_d_reg <= 1'b0;
    end else if (ce) begin
      rx_run_d_reg <= rx_run;
      if (clear_all) begin
        sync_flag_reg <= 1'b0;
        user_reg <= 2'h0;
      end else begin
        if (rx_wr_hi) begin
          sync_flag_reg <= rx_wdata[`SLTCS_RX_SYNC];
          user_reg <= rx_wdata[`SLTCS_RX_USER_HI:`SLTCS_RX_USER_LO];
        end
        if (rx_sync_set) begin
          sync_flag_reg <= 1'b1;
        end
        if (seq_clear_sync || (rx_run_d_reg && !rx_run)) begin
          sync_flag_reg <= 1'b0;
        end
      end
    end
  end

  // Serializer paced by rising edges of the modem's transmit clock, LSB first.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_clk_d_reg <= 1'b0;
      state_reg <= ST_IDLE;
      shift_reg <= {CHAR_BITS{1'b1}};
      bit_cnt_reg <= {CW{1'b0}};
      dle_sent_reg <= 1'b0;
      txd <= 1'b1;
      tx_active <= 1'b0;
    end else if (ce) begin
      tx_clk_d_reg <= tx_clk_s;
      if (!idle_fill || !transparent_mode) begin
        dle_sent_reg <= 1'b0;
      end
      if (tx_clk_rise) begin
        case (state_reg)
          ST_IDLE: begin
            txd <= 1'b1;
            if (load_any) begin
              shift_reg <= load_char;
              bit_cnt_reg <= CB_LAST[CW-1:0];
              state_reg <= ST_SHIFT;
              tx_active <= 1'b1;
              if (!load_mem && transparent_mode) begin
                dle_sent_reg <= !dle_sent_reg;
              end
            end else begin
              tx_active <= 1'b0;
            end
          end
          ST_SHIFT: begin
            txd <= shift_reg[0];
            shift_reg <= {1'b1, shift_reg[CHAR_BITS-1:1]};
            if (bit_cnt_reg != {CW{1'b0}}) begin
              bit_cnt_reg <= bit_cnt_reg - 1'b1;
            end else if (load_any) begin
              shift_reg <= load_char;
              bit_cnt_reg <= CB_LAST[CW-1:0];
              if (!load_mem && transparent_mode) begin
                dle_sent_reg <= !dle_sent_reg;
              end
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Registered outputs and read-back.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_rdata <= `SLTCS_TX_RESET;
      rx_rdata <= `SLTCS_RX_RESET;
      direct_memory_request <= 1'b0;
      pair_select <= 1'b0;
      error_flag <= 1'b0;
      vector_b_request <= 1'b0;
      user_option <= 2'h0;
    end else if (ce) begin
      tx_rdata <= 16'h0000;
      tx_rdata[`SLTCS_TX_GO] <= go_reg;
      tx_rdata[`SLTCS_TX_IDLE] <= idle_mode_reg;
      tx_rdata[`SLTCS_TX_PAIR] <= pair_reg;
      tx_rdata[`SLTCS_TX_ERROR_IRQ_ENABLE] <= error_irq_enable_reg;
      tx_rdata[`SLTCS_TX_MODEM_IE] <= modem_irq_enable_reg;
      tx_rdata[`SLTCS_DONE_IRQ_ENABLE] <= done_irq_enable_reg;
      tx_rdata[`SLTCS_TX_DONE_S] <= done_s_reg;
      tx_rdata[`SLTCS_TX_DONE_P] <= done_p_reg;
      rx_rdata <= 16'h0000;
      rx_rdata[`SLTCS_RX_SYNC] <= sync_flag_reg;
      rx_rdata[`SLTCS_RX_USER_HI:`SLTCS_RX_USER_LO] <= user_reg;
      direct_memory_request <= go_reg && mem_ready;
      pair_select <= pair_reg;
      error_flag <= err_any;
      vector_b_request <= (error_irq_enable_reg && err_any) ||
        (done_irq_enable_reg && (done_p_reg || done_s_reg));
      user_option <= user_reg;
    end
  end
endmodule

// [bench/sltcs_modem.sv]
`timescale 1ns/1ps
module sltcs_modem (
  input wire run,
  input wire txd,
  output reg tx_clk,
  output reg [15:0] line_bits
);
  // The clock stands still, low, while run is low, so stopping it is a real stall for the buffer.
  initial begin
    tx_clk = 1'h0;
    #5.3;
    forever begin
      #16;
      if (run || tx_clk) tx_clk = ~tx_clk;
    end
  end
  // Sampling on the rising edge sees the bit launched by the previous edge, long settled.
  always @(posedge tx_clk) line_bits <= {txd, line_bits[15:1]};
endmodule

// [bench/sltcs_props.sv]
`timescale 1ns/1ps
module sltcs_props (
  input wire core_clk,
  input wire rst,
  input wire bus_init,
  input wire master_clear,
  input wire rx_wr_hi,
  input wire [15:0] rx_wdata,
  input wire seq_clear_go,
  input wire seq_clear_sync,
  input wire vrc_error,
  input wire bcc_error,
  input wire nxm_flag,
  input wire latency_flag,
  input wire clock_loss_flag,
  input wire prim_count_zero,
  input wire sec_count_zero,
  input wire char_count_overflow,
  input wire [15:0] tx_rdata,
  input wire [15:0] rx_rdata,
  input wire direct_memory_request,
  input wire pair_select,
  input wire error_flag,
  input wire vector_b_request
);
  wire any_err = vrc_error | bcc_error | nxm_flag | latency_flag | clock_loss_flag;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Read-back lags the control state by one cycle, hence the short windows.
  go_seq_clr_a: assert property (seq_clear_go |-> ##[1:2] !tx_rdata[0])
    else $error("go kept after sequence clear");
  go_err_clr_a: assert property ($rose(nxm_flag | latency_flag | clock_loss_flag) |->
    ##[1:3] !tx_rdata[0])
    else $error("go kept after transfer error");
  go_zero_clr_a: assert property (prim_count_zero && sec_count_zero |->
    ##[1:2] !tx_rdata[0])
    else $error("go kept with both counts zero");
  dmr_go_a: assert property (direct_memory_request |-> tx_rdata[0])
    else $error("memory request without go");
  // The pair output trails its cause by two edges: one for the state, one for the port flop.
  pair_move_a: assert property ($changed(pair_select) |->
    $past(char_count_overflow, 2) || $past(bus_init, 2) || $past(master_clear, 2))
    else $error("pair moved without overflow");
  pair_init_a: assert property (bus_init || master_clear |-> ##2 !pair_select)
    else $error("pair not primary after clear");
  err_on_a: assert property (any_err [*2] |-> error_flag)
    else $error("error flag missing");
  err_off_a: assert property (!any_err [*2] |-> !error_flag)
    else $error("error flag without cause");
  vec_err_a: assert property ((error_flag && tx_rdata[3]) [*3] |-> vector_b_request)
    else $error("error vector request missing");
  done_p_a: assert property (char_count_overflow && tx_rdata[0] && !pair_select |->
    ##[1:3] tx_rdata[7])
    else $error("primary done not set");
  sync_clr_a: assert property (seq_clear_sync |-> ##2 !rx_rdata[12])
    else $error("sync flag kept after sequence clear");
  user_opt_a: assert property (rx_wr_hi |->
    ##2 rx_rdata[14:13] == $past(rx_wdata[14:13], 2))
    else $error("user option bits not written");
endmodule

bind sltcs_top sltcs_props u_props (
  .core_clk(core_clk), .rst(rst), .bus_init(bus_init), .master_clear(master_clear),
  .rx_wr_hi(rx_wr_hi), .rx_wdata(rx_wdata), .seq_clear_go(seq_clear_go),
  .seq_clear_sync(seq_clear_sync), .vrc_error(vrc_error), .bcc_error(bcc_error),
  .nxm_flag(nxm_flag), .latency_flag(latency_flag), .clock_loss_flag(clock_loss_flag),
  .prim_count_zero(prim_count_zero), .sec_count_zero(sec_count_zero),
  .char_count_overflow(char_count_overflow), .tx_rdata(tx_rdata), .rx_rdata(rx_rdata),
  .direct_memory_request(direct_memory_request), .pair_select(pair_select),
  .error_flag(error_flag), .vector_b_request(vector_b_request)
);

// [bench/tb_sltcs_top.sv]
`timescale 1ns/1ps
`include "sltcs_regs.vh"
module tb_sltcs_top;
  reg core_clk, rst, ce, bus_init, master_clear, tx_wr_lo, tx_wr_hi, rx_wr_hi;
  reg seq_clear_go, seq_clear_sync, rx_run, rx_sync_set, vrc_error, bcc_error;
  reg nxm_flag, latency_flag, clock_loss_flag, prim_count_zero, sec_count_zero;
  reg char_count_overflow, transparent_mode, mem_valid, modem_run;
  reg [15:0] tx_wdata, rx_wdata;
  reg [7:0] sync_char, mem_data;
  wire [15:0] tx_rdata, rx_rdata, line_bits;
  wire [1:0] user_option;
  wire mem_ready, direct_memory_request, tx_clk, txd, tx_active, pair_select;
  wire error_flag, vector_b_request;
  integer total_checks, miscompares, i, n;

  sltcs_top dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .bus_init(bus_init), .master_clear(master_clear),
    .tx_wr_lo(tx_wr_lo), .tx_wr_hi(tx_wr_hi), .tx_wdata(tx_wdata), .tx_rdata(tx_rdata),
    .rx_wr_hi(rx_wr_hi), .rx_wdata(rx_wdata), .rx_rdata(rx_rdata), .seq_clear_go(seq_clear_go),
    .seq_clear_sync(seq_clear_sync), .rx_run(rx_run), .rx_sync_set(rx_sync_set),
    .vrc_error(vrc_error), .bcc_error(bcc_error), .nxm_flag(nxm_flag),
    .latency_flag(latency_flag), .clock_loss_flag(clock_loss_flag),
    .prim_count_zero(prim_count_zero), .sec_count_zero(sec_count_zero),
    .char_count_overflow(char_count_overflow), .transparent_mode(transparent_mode),
    .sync_char(sync_char), .mem_valid(mem_valid), .mem_data(mem_data), .mem_ready(mem_ready),
    .direct_memory_request(direct_memory_request), .tx_clk(tx_clk), .txd(txd),
    .tx_active(tx_active), .pair_select(pair_select), .error_flag(error_flag),
    .vector_b_request(vector_b_request), .user_option(user_option)
  );
  sltcs_modem u_modem (.run(modem_run), .txd(txd), .tx_clk(tx_clk), .line_bits(line_bits));

  always #2 core_clk = ~core_clk;

  task cyc(input integer k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task chk(input string what, input [15:0] seen, input [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr_tx(input [15:0] d);
    tx_wdata = d;
    tx_wr_lo = 1'h1;
    cyc(1);
    tx_wr_lo = 1'h0;
    cyc(2);
  endtask

  // Idle stream phase is unknown, so every rotation of the pattern is accepted.
  function automatic bit rot_hit(input [15:0] w, input [15:0] p);
    reg [31:0] pp;
    integer k;
    rot_hit = 1'b0;
    for (k = 0; k < 16; k = k + 1) begin
      pp = {p, p} >> k;
      if (w === pp[15:0]) rot_hit = 1'b1;
    end
  endfunction

  task t_regs;
    chk("tx reset", tx_rdata, 16'h0000);
    chk("rx reset", rx_rdata, 16'h0000);
    chk("line idle", txd, 1'h1);
    // A write offered while the enable is low must leave no trace.
    ce = 1'h0;
    tx_wdata = 16'h0001;
    tx_wr_lo = 1'h1;
    cyc(2);
    tx_wr_lo = 1'h0;
    ce = 1'h1;
    cyc(2);
    chk("frozen write", tx_rdata, 16'h0000);
    wr_tx(16'h003e);
    chk("tx low byte", tx_rdata, 16'h003a);
    tx_wdata = 16'hffff;
    tx_wr_hi = 1'h1;
    cyc(1);
    tx_wr_hi = 1'h0;
    cyc(2);
    chk("tx high byte", tx_rdata, 16'h003a);
  endtask

  task t_rx;
    rx_wdata = 16'h7000;
    rx_wr_hi = 1'h1;
    cyc(1);
    rx_wr_hi = 1'h0;
    cyc(2);
    chk("rx write", rx_rdata, 16'h7000);
    chk("user bits", user_option, 2'h3);
    seq_clear_sync = 1'h1;
    cyc(1);
    seq_clear_sync = 1'h0;
    cyc(2);
    chk("sequence sync clear", rx_rdata, 16'h6000);
    rx_run = 1'h1;
    rx_sync_set = 1'h1;
    cyc(1);
    rx_sync_set = 1'h0;
    cyc(2);
    chk("sync set", rx_rdata, 16'h7000);
    rx_run = 1'h0;
    cyc(3);
    chk("run drop clear", rx_rdata, 16'h6000);
  endtask

  task t_go_clear;
    for (i = 0; i < 7; i = i + 1) begin
      wr_tx(16'h0009);
      chk("go set", tx_rdata[0], 1'h1);
      {bcc_error, vrc_error, prim_count_zero, clock_loss_flag, latency_flag, nxm_flag,
        seq_clear_go} = 7'h01 << i;
      sec_count_zero = prim_count_zero;
      cyc(1);
      seq_clear_go = 1'h0;
      cyc(2);
      chk("go after cause", tx_rdata[0], i > 4);
      chk("error flag", error_flag, i % 4 != 0);
      chk("error vector", vector_b_request, i % 4 != 0);
      {bcc_error, vrc_error, prim_count_zero, sec_count_zero, clock_loss_flag, latency_flag,
        nxm_flag} = 7'h00;
      cyc(2);
      chk("error cleared", error_flag, 1'h0);
    end
  endtask

  task ovf(input [15:0] exp);
    char_count_overflow = 1'h1;
    cyc(1);
    char_count_overflow = 1'h0;
    cyc(2);
    chk("after overflow", tx_rdata, exp);
  endtask

  task t_pair;
    wr_tx(16'h0021);
    ovf(16'h00a5);
    chk("done vector", vector_b_request, 1'h1);
    chk("pair select", pair_select, 1'h1);
    ovf(16'h00e1);
    wr_tx(16'h0001);
    ovf(16'h0085);
    wr_tx(16'h0000);
    chk("pair kept on stop", tx_rdata, 16'h0004);
    wr_tx(16'h0001);
    chk("pair reused", tx_rdata, 16'h0005);
    master_clear = 1'h1;
    cyc(1);
    master_clear = 1'h0;
    cyc(2);
    chk("master clear", tx_rdata, 16'h0000);
  endtask

  task t_idle;
    for (i = 0; i < 2; i = i + 1) begin
      transparent_mode = i[0];
      wr_tx(16'h0002);
      modem_run = 1'h1;
      #1600;
      modem_run = 1'h0;
      cyc(10);
      chk("idle fill", rot_hit(line_bits, i ? {sync_char, `SLTCS_DLE_CHAR} : {2{sync_char}}),
        1'h1);
      chk("line active", tx_active, 1'h1);
    end
  endtask

  task t_fifo;
    wr_tx(16'h0001);
    n = 0;
    mem_valid = 1'h1;
    for (i = 0; i < 10; i = i + 1) begin
      mem_data = 8'h5a;
      if (mem_ready === 1'h1) n = n + 1;
      cyc(1);
    end
    mem_valid = 1'h0;
    chk("words taken", n, 16'h0004);
    chk("request while full", direct_memory_request, 1'h0);
    modem_run = 1'h1;
    #1600;
    modem_run = 1'h0;
    cyc(10);
    chk("drained", {direct_memory_request, mem_ready}, 2'h3);
    bus_init = 1'h1;
    cyc(1);
    bus_init = 1'h0;
    cyc(2);
    chk("bus init", tx_rdata, 16'h0000);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {core_clk, bus_init, master_clear, tx_wr_lo, tx_wr_hi, rx_wr_hi, seq_clear_go,
      seq_clear_sync, rx_run, rx_sync_set, vrc_error, bcc_error, nxm_flag, latency_flag,
      clock_loss_flag, prim_count_zero, sec_count_zero, char_count_overflow,
      transparent_mode, mem_valid, modem_run, tx_wdata, rx_wdata, mem_data} = '0;
    rst = 1'h1;
    ce = 1'h1;
    sync_char = 8'h96;
    total_checks = 0;
    miscompares = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'h0;
    cyc(1);
    t_regs;
    t_rx;
    t_go_clear;
    t_pair;
    t_idle;
    t_fifo;
    end_of_test;
  end

  initial begin
    #100000;
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule
